// ==== hw/hps_slot_cfg.sv ====
// Purpose: hot-plug slot signal configuration and power/reset sequencing
// Assumes: AHB-Lite slave, slot pins synchronous to clk_in
// Notes:   configuration survives hot_reset_in, cleared by reset_n_in only
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - slot input polarity inverts per config bit
// - slot output polarity inverts per config bit, except slot_reset_n_out, which has no inversion bit
// - open latch forces slot power off
// - latch input may serve as lock state
// - interlock pulses 125 ms per write
// - toggle mode flips interlock per write
// - reset output follows selected mode source
// - wait count x 10 ms before reset negation
// - wait count x 10 ms before power off
module hps_slot_cfg
    import hps_pkg::*;
#(
    parameter int unsigned UNIT_CYCLES  = DELAY_UNIT_CYC,
    parameter int unsigned PULSE_CYCLES = PULSE_CYC
) (
    // clock and reset
    input  wire logic          clk_in,
    input  wire logic          reset_n_in,
    input  wire logic          hot_reset_in,
    // ahb-lite slave
    input  wire logic          hsel_in,
    input  wire logic [31:0]   haddr_in,
    input  wire logic [1:0]    htrans_in,
    input  wire logic          hwrite_in,
    input  wire logic [2:0]    hsize_in,
    input  wire logic [31:0]   hwdata_in,
    input  wire logic          hready_in,
    output logic               hreadyout_out,
    output logic               hresp_out,
    output logic [31:0]        hrdata_out,
    // slot inputs
    input  wire logic [NP-1:0] slot_attn_button_in,
    input  wire logic [NP-1:0] slot_presence_in,
    input  wire logic [NP-1:0] slot_power_fault_in,
    input  wire logic [NP-1:0] slot_latch_sensor_in,
    input  wire logic [NP-1:0] slot_power_good_in,
    // slot outputs
    output logic [NP-1:0]      slot_attn_indicator_out,
    output logic [NP-1:0]      slot_power_indicator_out,
    output logic [NP-1:0]      slot_power_enable_out,
    output logic [NP-1:0]      slot_interlock_out,
    output logic [NP-1:0]      slot_reset_n_out
);

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic sensed(input logic pin, input logic inv);
        sensed = (pin == inv);
    endfunction : sensed

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // ------------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------------
    hps_cfg_s          cfg;
    logic [31:0]       ctl;
    logic [31:0]       sts_word;
    logic              dp_wr;
    logic              dp_rd;
    logic              rd_ready;
    logic [ADDR_W-1:0] dp_addr;
    wire               take    = hsel_in & htrans_in[1] & hready_in & (hsize_in == HSIZE_WORD);
    wire               wr_cfg  = dp_wr & hit(dp_addr, OFS_CFG);
    wire               wr_ctl  = dp_wr & hit(dp_addr, OFS_CTL);
    wire [31:0]        rd_val  = hit(dp_addr, OFS_CFG) ? cfg :
                                 hit(dp_addr, OFS_CTL) ? (ctl & CTL_WMASK) :
                                 hit(dp_addr, OFS_STS) ? sts_word : '0;

    assign hreadyout_out = ~(dp_rd & ~rd_ready);
    assign hresp_out     = 1'b0;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dp_wr      <= 1'b0;
            dp_rd      <= 1'b0;
            rd_ready   <= 1'b0;
            dp_addr    <= '0;
            hrdata_out <= '0;
        end else if (hreadyout_out) begin
            dp_wr      <= take & hwrite_in;
            dp_rd      <= take & ~hwrite_in;
            rd_ready   <= 1'b0;
            dp_addr    <= take ? haddr_in[ADDR_W-1:0] : dp_addr;
        end else begin
            rd_ready   <= 1'b1;
            hrdata_out <= rd_val;
        end
    end

    // ------------------------------------------------------------------
    // configuration and slot control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cfg <= CFG_RESET;
            ctl <= CTL_RESET;
        end else begin
            if (wr_cfg) begin
                cfg <= hwdata_in & CFG_WMASK;
            end
            if (wr_ctl) begin
                ctl <= hwdata_in & CTL_WMASK;
            end
        end
    end

    // ------------------------------------------------------------------
    // per-slot sequencing
    // ------------------------------------------------------------------
    hps_rst_mode_e   mode;
    hps_slot_state_e st [NP];
    hps_slot_state_e next_st [NP];
    logic [NP-1:0]   ilock_lvl;
    logic [NP-1:0]   next_ilock;
    logic [NP-1:0]   latch_open;
    logic [NP-1:0]   eic_set;
    logic [NP-1:0]   rst_active;
    logic [NP-1:0]   ramp_done;
    logic [NP-1:0]   drain_done;

    assign mode = hps_rst_mode_e'(cfg.downstream_reset_mode);
    assign sts_word[31:NP*STS_STRIDE] = '0;

    for (genvar p = 0; p < NP; p++) begin : g_slot
        wire lock_in  = sensed(slot_latch_sensor_in[p], cfg.inv_latch_sensor);
        wire pgood    = sensed(slot_power_good_in[p], cfg.inv_power_good);
        wire kill     = cfg.latch_open_auto_power_off & ctl[CTL_LP+p] & latch_open[p];
        wire req      = ~ctl[CTL_PCC+p] & ~kill;
        wire stable   = (mode == RM_PWR_GOOD) ? pgood : 1'b1;
        wire pulse_dn;

        assign latch_open[p] = lock_in & ~cfg.latch_as_lock_state;
        assign eic_set[p]    = wr_ctl & hwdata_in[CTL_EIC+p];
        assign rst_active[p] = (mode == RM_HOT) ? hot_reset_in : (st[p] != ST_ON);
        assign sts_word[p*STS_STRIDE +: STS_STRIDE] = {
            rst_active[p], st[p] != ST_OFF, pgood,
            lock_in & cfg.latch_as_lock_state, latch_open[p],
            sensed(slot_power_fault_in[p], cfg.inv_power_fault),
            sensed(slot_presence_in[p], cfg.inv_presence),
            sensed(slot_attn_button_in[p], cfg.inv_attn_button)};

        hps_delay_timer #(.UNIT_CYCLES(UNIT_CYCLES)) u_ramp (
            .clk_in     (clk_in),
            .reset_n_in (reset_n_in),
            .run_in     ((st[p] == ST_RAMP) & stable),
            .units_in   (cfg.power_to_reset_delay),
            .done_out   (ramp_done[p])
        );

        hps_delay_timer #(.UNIT_CYCLES(UNIT_CYCLES)) u_drain (
            .clk_in     (clk_in),
            .reset_n_in (reset_n_in),
            .run_in     (st[p] == ST_DRAIN),
            .units_in   (cfg.reset_to_power_off_delay),
            .done_out   (drain_done[p])
        );

        hps_delay_timer #(.UNIT_CYCLES(PULSE_CYCLES)) u_pulse (
            .clk_in     (clk_in),
            .reset_n_in (reset_n_in),
            .run_in     (ilock_lvl[p] & ~cfg.interlock_toggle_select),
            .units_in   (ONE_UNIT),
            .done_out   (pulse_dn)
        );

        always_comb begin
            next_st[p] = st[p];
            unique case (st[p])
                ST_OFF:   next_st[p] = req ? ST_RAMP : ST_OFF;
                ST_RAMP:  next_st[p] = !req ? ST_OFF : ramp_done[p] ? ST_ON : ST_RAMP;
                ST_ON:    next_st[p] = req ? ST_ON : ST_DRAIN;
                ST_DRAIN: next_st[p] = drain_done[p] ? ST_OFF : ST_DRAIN;
            endcase
        end

        assign next_ilock[p] = cfg.interlock_toggle_select ?
                               (ilock_lvl[p] ^ eic_set[p]) :
                               (eic_set[p] | (ilock_lvl[p] & ~pulse_dn));
    end

    // ------------------------------------------------------------------
    // state and registered slot outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ilock_lvl                <= '0;
            slot_attn_indicator_out  <= '1;
            slot_power_indicator_out <= '1;
            slot_power_enable_out    <= '0;
            slot_interlock_out       <= '0;
            slot_reset_n_out         <= '0;
            for (int i = 0; i < NP; i++) begin
                st[i] <= ST_OFF;
            end
        end else begin
            ilock_lvl <= next_ilock;
            for (int i = 0; i < NP; i++) begin
                st[i]                       <= next_st[i];
                slot_attn_indicator_out[i]  <= ~ctl[CTL_AI+i] ^ cfg.inv_attn_indicator;
                slot_power_indicator_out[i] <= ~ctl[CTL_PI+i] ^ cfg.inv_power_indicator;
                slot_power_enable_out[i]    <= (st[i] != ST_OFF) ^ cfg.inv_power_enable;
                slot_interlock_out[i]       <= ilock_lvl[i] ^ cfg.inv_interlock;
                slot_reset_n_out[i]         <= ~rst_active[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    a_pe_polarity: assert property (
        ##1 slot_power_enable_out[0] == (($past(st[0]) != ST_OFF) ^ $past(cfg.inv_power_enable)))
        else $error("power enable polarity wrong");
    a_pgood_sense: assert property (
        (st[0] == ST_RAMP && mode == RM_PWR_GOOD
         && slot_power_good_in[0] != cfg.inv_power_good) |=> st[0] != ST_ON)
        else $error("reset released without sensed power good");
    a_auto_off: assert property (
        (st[0] == ST_ON && cfg.latch_open_auto_power_off && ctl[CTL_LP] && latch_open[0])
        |=> st[0] == ST_DRAIN)
        else $error("open latch did not start power off");
    a_lock_no_off: assert property (
        (st[0] == ST_ON && cfg.latch_as_lock_state && !ctl[CTL_PCC]) |=> st[0] == ST_ON)
        else $error("lock state input removed power");
    a_pulse_start: assert property (
        (eic_set[0] && !cfg.interlock_toggle_select) |=> ilock_lvl[0] ##1 slot_interlock_out[0] != cfg.inv_interlock)
        else $error("interlock pulse not started");
    a_toggle_flip: assert property (
        (eic_set[0] && cfg.interlock_toggle_select) |=> ilock_lvl[0] != $past(ilock_lvl[0]))
        else $error("interlock level not flipped");
    a_hot_mode_rst: assert property (
        (mode == RM_HOT) |=> slot_reset_n_out[0] == !$past(hot_reset_in))
        else $error("reset does not follow hot reset");
    a_zero_ramp: assert property (
        (st[0] == ST_RAMP && cfg.power_to_reset_delay == 8'h00 && mode != RM_PWR_GOOD
         && !ctl[CTL_PCC] && !latch_open[0]) |=> st[0] == ST_ON)
        else $error("zero ramp delay not immediate");
    a_drain_hold: assert property (
        (st[0] == ST_ON ##1 st[0] == ST_DRAIN && cfg.reset_to_power_off_delay != 8'h00
         && !drain_done[0]) |=> st[0] == ST_DRAIN)
        else $error("power dropped before reset delay");
    a_cfg_keep: assert property (
        (hot_reset_in && !wr_cfg) |=> cfg == $past(cfg))
        else $error("configuration changed by hot reset");

    c_power_up: cover property (st[0] == ST_RAMP ##1 st[0] == ST_ON);
    c_power_down: cover property (st[0] == ST_DRAIN ##1 st[0] == ST_OFF);
    c_pulse_end: cover property (ilock_lvl[0] ##1 !ilock_lvl[0]);
    c_auto_off: cover property (st[0] == ST_ON && latch_open[0] && cfg.latch_open_auto_power_off);

endmodule : hps_slot_cfg
`default_nettype wire

// ==== hw/hps_pkg.sv ====
// Purpose: shared constants and types of the hot-plug slot configuration block
// Assumes: 250 MHz core clock, two downstream slots
// Notes:   register offsets are byte addresses on the AHB-Lite slave
package hps_pkg;

    // ------------------------------------------------------------------
    // sizes and bus
    // ------------------------------------------------------------------
    localparam int          NP          = 2;
    localparam int          ADDR_W      = 12;
    localparam int          STS_STRIDE  = 8;
    localparam logic [2:0]  HSIZE_WORD  = 3'h2;
    localparam logic [11:0] OFS_CFG     = 12'h330;
    localparam logic [11:0] OFS_CTL     = 12'h350;
    localparam logic [11:0] OFS_STS     = 12'h354;

    // ------------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [31:0] CFG_RESET   = 32'h1414_0800;
    localparam logic [31:0] CFG_WMASK   = 32'hffff_f9ff;
    localparam logic [31:0] CTL_RESET   = 32'h0003_0003;
    localparam logic [31:0] CTL_WMASK   = 32'h3303_0003;
    localparam int          CTL_PCC     = 0;
    localparam int          CTL_EIC     = 8;
    localparam int          CTL_LP      = 16;
    localparam int          CTL_AI      = 24;
    localparam int          CTL_PI      = 28;
    localparam logic [7:0]  ONE_UNIT    = 8'h01;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ       = 250;
    localparam int unsigned DELAY_UNIT_MS = 10;
    localparam int unsigned PULSE_MS      = 125;
    localparam int unsigned DELAY_UNIT_CYC = DELAY_UNIT_MS * 1000 * CLK_MHZ;
    localparam int unsigned PULSE_CYC      = PULSE_MS * 1000 * CLK_MHZ;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RM_PWR_EN   = 2'h0,
        RM_PWR_GOOD = 2'h1,
        RM_HOT      = 2'h2,
        RM_RSVD     = 2'h3
    } hps_rst_mode_e;

    typedef enum logic [1:0] {
        ST_OFF   = 2'h0,
        ST_RAMP  = 2'h1,
        ST_ON    = 2'h3,
        ST_DRAIN = 2'h2
    } hps_slot_state_e;

    typedef struct packed {
        logic [7:0] reset_to_power_off_delay;
        logic [7:0] power_to_reset_delay;
        logic [1:0] downstream_reset_mode;
        logic       interlock_toggle_select;
        logic       latch_as_lock_state;
        logic       latch_open_auto_power_off;
        logic [1:0] rsvd;
        logic       inv_power_good;
        logic       inv_interlock;
        logic       inv_power_enable;
        logic       inv_power_indicator;
        logic       inv_attn_indicator;
        logic       inv_latch_sensor;
        logic       inv_power_fault;
        logic       inv_presence;
        logic       inv_attn_button;
    } hps_cfg_s;

endpackage : hps_pkg

// ==== hw/hps_delay_timer.sv ====
// Purpose: counts whole units of a fixed number of clock cycles
// Assumes: run_in low clears the count
// Notes:   done_out is immediate when units_in is zero
`timescale 1ns/1ps
`default_nettype none
module hps_delay_timer
    import hps_pkg::*;
#(
    parameter int unsigned UNIT_CYCLES = DELAY_UNIT_CYC
) (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    // control
    input  wire logic       run_in,
    input  wire logic [7:0] units_in,
    // status
    output logic            done_out
);

    logic [31:0] cyc;
    logic [7:0]  units_done;
    wire         unit_end = (cyc == (UNIT_CYCLES[31:0] - 32'h1));

    assign done_out = run_in & (units_done >= units_in);

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cyc        <= '0;
            units_done <= '0;
        end else if (!run_in) begin
            cyc        <= '0;
            units_done <= '0;
        end else if (!done_out) begin
            cyc        <= unit_end ? '0 : cyc + 32'h1;
            units_done <= unit_end ? units_done + 8'h1 : units_done;
        end
    end

endmodule : hps_delay_timer
`default_nettype wire

// ==== dv/hps_slot_model.sv ====
// Purpose: far-side slot power controller, reports power good after a ramp
// Assumes: power enable active high, power good active low, unless the inversion inputs are set
// Notes:   power good drops at once when power is removed or a glitch is commanded
`timescale 1ns/1ps
`default_nettype none
module hps_slot_model
    import hps_pkg::*;
#(
    parameter int RAMP = 7
) (
    // clock
    input  wire logic          clk_in,
    // slot pins and polarity
    input  wire logic [NP-1:0] power_enable_in,
    input  wire logic          inv_enable_in,
    input  wire logic          inv_good_in,
    input  wire logic          glitch_in,
    output logic [NP-1:0]      power_good_out
);
    // ------------------------------------------------------------------
    // ramp counters
    // ------------------------------------------------------------------
    int            ramp_cnt [NP];
    logic [NP-1:0] good;
    always_ff @(posedge clk_in) begin
        for (int p = 0; p < NP; p++) begin
            if ((power_enable_in[p] ^ inv_enable_in) !== 1'b1) begin
                ramp_cnt[p] <= 0;
            end else if (ramp_cnt[p] < RAMP) begin
                ramp_cnt[p] <= ramp_cnt[p] + 1;
            end
        end
    end
    always_comb begin
        for (int p = 0; p < NP; p++) begin
            good[p] = (ramp_cnt[p] >= RAMP) && (power_enable_in[p] ^ inv_enable_in) && !glitch_in;
        end
    end
    assign power_good_out = ~good ^ {NP{inv_good_in}};
endmodule : hps_slot_model
`default_nettype wire

// ==== dv/tb_top.sv ====
// Purpose: self-checking bench of the hot-plug slot configuration block
// Assumes: short timer parameters, default polarity outside the register and polarity tests
// Notes:   reference register values are kept in the bench
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import hps_pkg::*;
();
    // ------------------------------------------------------------------
    // signals and reference model
    // ------------------------------------------------------------------
    localparam int          UNIT  = 10;
    localparam int          PULSE = 20;
    localparam logic [11:0] UNMAP = 12'h334;
    logic          clk_in = 1'b0;
    logic          reset_n_in = 1'b0;
    logic          hot_reset = 1'b0;
    logic          hsel = 1'b0;
    logic [31:0]   haddr = 32'h0;
    logic [1:0]    htrans = 2'h0;
    logic          hwrite = 1'b0;
    logic [31:0]   hwdata = 32'h0;
    logic          glitch = 1'b0;
    logic [NP-1:0] attn = '1, pres = '1, fault = '1, latch = '1;
    wire logic          hready;
    wire logic [31:0]   hrdata;
    wire logic          hresp;
    wire logic [NP-1:0] pgood, ai, pi, pe, il, rst_n;
    logic [31:0]   cfg_m = CFG_RESET;
    logic [31:0]   ctl_m = CTL_RESET;
    logic [31:0]   lfsr = 32'ha2b9ae89;
    logic [31:0]   c;
    logic [31:0]   st;
    int            n;
    int            mismatches = 0;
    int            num_checks = 0;

    hps_slot_cfg #(.UNIT_CYCLES(UNIT), .PULSE_CYCLES(PULSE)) dut (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .hot_reset_in(hot_reset),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(HSIZE_WORD), .hwdata_in(hwdata), .hready_in(hready),
        .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
        .slot_attn_button_in(attn), .slot_presence_in(pres), .slot_power_fault_in(fault),
        .slot_latch_sensor_in(latch), .slot_power_good_in(pgood),
        .slot_attn_indicator_out(ai), .slot_power_indicator_out(pi),
        .slot_power_enable_out(pe), .slot_interlock_out(il), .slot_reset_n_out(rst_n));
    hps_slot_model u_slot (
        .clk_in(clk_in), .power_enable_in(pe), .inv_enable_in(cfg_m[6]),
        .inv_good_in(cfg_m[8]), .glitch_in(glitch), .power_good_out(pgood));

    initial begin
        forever #2 clk_in = ~clk_in;
    end

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic rng(input string nm, input int v, input int lo, input int hi);
        chk(nm, 32'(v >= lo && v <= hi), 32'h1);
    endtask : rng
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk_in);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk_in); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_in); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
        if (a == OFS_CFG) cfg_m = d & CFG_WMASK;
        if (a == OFS_CTL) ctl_m = d & CTL_WMASK;
    endtask : wr
    task automatic rdchk(input logic [11:0] a);
        logic [31:0] d;
        ahb(1'b0, a, 32'h0, d);
        chk("register", d, a == OFS_CFG ? cfg_m : a == OFS_CTL ? ctl_m : 32'h0);
        chk("response", hresp, 32'h0);
    endtask : rdchk
    function automatic logic probe(input int sel);
        case (sel)
            0: return rst_n[0];
            1: return ~rst_n[0];
            2: return pe[0];
            3: return ~pe[0];
            4: return il[0];
            5: return ~il[0];
            default: return ~pgood[0];
        endcase
    endfunction : probe
    task automatic wait_for(input int sel, output int cnt);
        cnt = 0;
        while (probe(sel) !== 1'b1 && cnt < 2000) begin
            @(posedge clk_in);
            cnt++;
        end
        if (cnt >= 2000) begin
            chk("wait limit", 32'h0, 32'h1);
        end
    endtask : wait_for
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        #200000;
        mismatches++;
        $display("watchdog expired");
        end_sim();
    end
    initial begin
        repeat (5) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rdchk(OFS_CFG);
        rdchk(OFS_CTL);
        wr(UNMAP, 32'hffff_ffff);
        rdchk(UNMAP);
        wr(OFS_CFG, 32'hffff_ffff);
        rdchk(OFS_CFG);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            c = CFG_RESET | (lfsr & 32'h0000_01ff);
            {attn, pres, fault, latch} <= lfsr[17:10];
            wr(OFS_CFG, c);
            wr(OFS_CTL, CTL_RESET | (lfsr & 32'h3300_0000));
            ahb(1'b0, OFS_STS, 32'h0, st);
            for (int p = 0; p < NP; p++) begin
                chk("status", st[p*8 +: 8], {4'h8, ~latch[p] ^ c[3], ~fault[p] ^ c[2],
                    ~pres[p] ^ c[1], ~attn[p] ^ c[0]});
            end
            chk("attn ind", ai, {~ctl_m[25:24] ^ {NP{c[4]}}});
            chk("power ind", pi, {~ctl_m[29:28] ^ {NP{c[5]}}});
            chk("power en", pe, {NP{c[6]}});
            chk("interlock", il, {NP{c[7]}});
        end
        {attn, pres, fault, latch} <= '1;
        $display("test polarity done");
        wr(OFS_CFG, 32'h0305_4800);
        wr(OFS_CTL, 32'h0003_0002);
        wait_for(6, n);
        chk("reset held", rst_n[0], 1'b0);
        repeat (2 * UNIT) @(posedge clk_in);
        chk("reset early", rst_n[0], 1'b0);
        glitch <= 1'b1;
        repeat (3) @(posedge clk_in);
        glitch <= 1'b0;
        wait_for(0, n);
        rng("power to reset", n, 5 * UNIT - 1, 5 * UNIT + 4);
        wr(OFS_CTL, CTL_RESET);
        wait_for(1, n);
        rng("reset on drop", n, 0, 3);
        wait_for(3, n);
        rng("reset to off", n, 3 * UNIT - 1, 3 * UNIT + 4);
        wr(OFS_CFG, 32'h0000_0800);
        wr(OFS_CTL, 32'h0003_0002);
        wait_for(2, n);
        wait_for(0, n);
        rng("zero delay on", n, 0, 3);
        wr(OFS_CTL, CTL_RESET);
        wait_for(3, n);
        rng("zero delay off", n, 0, 4);
        $display("test sequencing done");
        wr(OFS_CFG, 32'h0202_0800);
        wr(OFS_CTL, 32'h0003_0002);
        wait_for(0, n);
        latch <= 2'b10;
        wait_for(3, n);
        rng("latch kill", n, 2 * UNIT - 1, 2 * UNIT + 5);
        latch <= 2'b11;
        wr(OFS_CFG, 32'h0202_1800);
        wait_for(0, n);
        latch <= 2'b10;
        repeat (3 * UNIT) @(posedge clk_in);
        chk("lock no kill", pe[0], 1'b1);
        ahb(1'b0, OFS_STS, 32'h0, st);
        chk("lock state", st[4:3], 2'h2);
        latch <= 2'b11;
        wr(OFS_CTL, CTL_RESET);
        wait_for(3, n);
        $display("test latch done");
        wr(OFS_CTL, CTL_RESET | 32'h100);
        wait_for(4, n);
        wait_for(5, n);
        rng("pulse width", n, PULSE - 1, PULSE + 1);
        wr(OFS_CFG, cfg_m | 32'h2000);
        for (int k = 0; k < 2; k++) begin
            wr(OFS_CTL, CTL_RESET | 32'h300);
            repeat (3) @(posedge clk_in);
            chk("toggle", il, k ? 2'b00 : 2'b11);
        end
        $display("test interlock done");
        wr(OFS_CFG, 32'h1414_8800);
        hot_reset <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk("hot reset out", rst_n, 2'b00);
        rdchk(OFS_CFG);
        hot_reset <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk("hot reset gone", rst_n, 2'b11);
        rdchk(OFS_CFG);
        $display("test hot reset done");
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
